// ---- hw/mfr_consts.svh ----
// Purpose: named offsets, fields, reset values and timing for the frame register block
// Assumes: byte addressing on the register bus, 32-bit data
// Notes:   definitions only
`ifndef MFR_CONSTS_SVH
`define MFR_CONSTS_SVH

// ==========================================================================
// register offsets
`define MFR_OFS_FRAME      5'h00
`define MFR_OFS_CONFIG     5'h04
`define MFR_OFS_STATUS     5'h08
`define MFR_OFS_INT_STAT   5'h0C
`define MFR_OFS_INT_MASK   5'h10

// ==========================================================================
// frame fields
`define MFR_BIT_MUST_ZERO  31
`define MFR_BIT_CLAUSE     30
`define MFR_KIND_HI        29
`define MFR_KIND_LO        28
`define MFR_PHY_HI         27
`define MFR_PHY_LO         23
`define MFR_REG_HI         22
`define MFR_REG_LO         18
`define MFR_TA_HI          17
`define MFR_TA_LO          16
`define MFR_KIND_WRITE     2'h1
`define MFR_KIND_READ      2'h2
`define MFR_TA_CODE        2'h2
`define MFR_FRAME_RESET    32'h0000_0000

// ==========================================================================
// config, status and interrupt fields
`define MFR_CFG_DIV_HI     18
`define MFR_CFG_DIV_LO     16
`define MFR_CFG_RESET      32'h0002_0000
`define MFR_STAT_IDLE_BIT  2
`define MFR_INT_DONE_BIT   0
`define MFR_INT_RESET      32'h0000_0000

// ==========================================================================
// frame timing
`define MFR_FRAME_BITS     6'h20
`define MFR_PREAMBLE_BITS  6'h20
`define MFR_READ_DRIVE     6'h0E
`define MFR_MCLK_HZ        10000000
`define MFR_MDC_MAX_HZ     2500000

// master clock divisors per ratio code
`define MFR_DIV0           8'h08
`define MFR_DIV1           8'h10
`define MFR_DIV2           8'h20
`define MFR_DIV3           8'h30
`define MFR_DIV4           8'h40
`define MFR_DIV5           8'h60
`define MFR_DIV6           8'h80
`define MFR_DIV7           8'hE0

`endif

// ---- hw/mfr_pkg.sv ----
// Purpose: types shared by the frame register block
// Assumes: nothing
// Notes:   constants live in mfr_consts.svh
package mfr_pkg;
   typedef enum logic [1:0] {
      MFR_IDLE,
      MFR_PREAMBLE,
      MFR_SHIFT
   } mfr_state_t;
endpackage

// ---- hw/mfr_mdc_gen.sv ----
// Purpose: divides the master clock down to the management clock
// Assumes: divisors are even
// Notes:   ticks are registered and mark each edge of the divided clock
`timescale 1ns/1ps
`include "mfr_consts.svh"

module mfr_mdc_gen import mfr_pkg::*; #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // control
   input  wire logic             run,
   input  wire logic [2:0]       ratioSel,
   // divided clock
   output logic                  mdcLevel,
   output logic                  riseTick,
   output logic                  fallTick
);

   // refuse a counter too narrow for the largest divisor
   if (CNT_W < 8) begin : g_cnt_check
      $error("mfr_mdc_gen: CNT_W too small for divisors");
   end

   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic             lvl_reg, lvl_next;
   logic             rise_reg, rise_next;
   logic             fall_reg, fall_next;
   logic [7:0]       divisor;

   // ==========================================================================
   // divider
   always_comb begin
      case (ratioSel)
         3'h0:    divisor = `MFR_DIV0;
         3'h1:    divisor = `MFR_DIV1;
         3'h2:    divisor = `MFR_DIV2;
         3'h3:    divisor = `MFR_DIV3;
         3'h4:    divisor = `MFR_DIV4;
         3'h5:    divisor = `MFR_DIV5;
         3'h6:    divisor = `MFR_DIV6;
         default: divisor = `MFR_DIV7;
      endcase
      cnt_next  = cnt_reg;
      lvl_next  = lvl_reg;
      rise_next = 1'b0;
      fall_next = 1'b0;
      if (!run) begin
         cnt_next = '0;
         lvl_next = 1'b0;
      end else if (cnt_reg == CNT_W'(divisor[7:1] - 7'h01)) begin // [RL10]
         cnt_next  = '0;
         lvl_next  = !lvl_reg;
         rise_next = !lvl_reg;
         fall_next = lvl_reg;
      end else begin
         cnt_next = cnt_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_reg  <= '0;
         lvl_reg  <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         lvl_reg  <= lvl_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
      end
   end

   assign mdcLevel = lvl_reg;
   assign riseTick = rise_reg;
   assign fallTick = fall_reg;

endmodule // mfr_mdc_gen

// ---- hw/mfr_mdio_frame_register.sv ----
// Purpose: management frame register that shifts a frame out on the data pin
// Assumes: Avalon-MM slave with waitrequest, single clock, synchronous reset
// Notes:   frame is preceded by a preamble of ones; register is the shift register
//
// Function
// (RL1) Software keeps the top bit of the frame register zero.
// (RL2) Bit 30 picks clause 45 framing when zero and clause 22 when one.
// (RL3) Bits 29:28 hold 01 for a write and 10 for a read, other codes reserved.
// (RL4) Bits 27:23 carry the address of the attached PHY.
// (RL5) Bits 22:18 carry the register index inside that PHY.
// (RL6) Software loads the turnaround bits 17:16 with 10.
// (RL7) A frame register write starts a shift, and its end sets status bit 2 and an interrupt.
// (RL8) The top bit goes out and the bottom bit comes in once per management clock cycle.
// (RL9) Reads mid-shift show the shift register, which ends restored with read data captured.
// (RL10) The management clock is the master clock divided by a three-bit ratio field.
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "mfr_consts.svh"

module mfr_mdio_frame_register import mfr_pkg::*; (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // register bus
   input  wire logic [4:0]       avsAddress,
   input  wire logic             avsRead,
   input  wire logic             avsWrite,
   input  wire logic [31:0]      avsWritedata,
   input  wire logic [3:0]       avsByteenable,
   output logic [31:0]           avsReaddata,
   output logic                  avsWaitrequest,
   // management pins
   output logic                  mdc,
   input  wire logic             mdioIn,
   output logic                  mdioOut,
   output logic                  mdioOe,
   // interrupt
   output logic                  irq
);

   mfr_state_t  state_reg, state_next;
   logic [31:0] frame_reg, frame_next;
   logic [31:0] cfg_reg, cfg_next;
   logic [31:0] intStat_reg, intStat_next;
   logic [31:0] intMask_reg, intMask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        wait_reg, wait_next;
   logic [5:0]  bitCnt_reg, bitCnt_next;
   logic        sample_reg, sample_next;
   logic        out_reg, out_next;
   logic        oe_reg, oe_next;
   logic        mdc_reg;
   logic        irq_reg, irq_next;
   logic        mdcLevel, riseTick, fallTick;
   logic        readOp_reg, readOp_next;
   logic        wrTaken, doneEvt;
   logic [31:0] readMux;
   wire  [31:0] beMask;

   // ==========================================================================
   // management clock
   mfr_mdc_gen #(.CNT_W(8)) mdcGen (
      .mclk     (mclk),
      .reset    (reset),
      .run      (state_reg != MFR_IDLE),
      .ratioSel (cfg_reg[`MFR_CFG_DIV_HI:`MFR_CFG_DIV_LO]),
      .mdcLevel (mdcLevel),
      .riseTick (riseTick),
      .fallTick (fallTick)
   );

   // ==========================================================================
   // byte lane masks
   for (genvar lane = 0; lane < 4; lane++) begin : g_lane
      assign beMask[lane*8 +: 8] = {8{avsByteenable[lane]}};
   end

   // ==========================================================================
   // bus slave: one wait cycle, then one ready cycle
   always_comb begin
      wrTaken = avsWrite && !wait_reg;
      case (avsAddress)
         `MFR_OFS_FRAME:    readMux = frame_reg; // [RL9]
         `MFR_OFS_CONFIG:   readMux = cfg_reg;
         `MFR_OFS_STATUS:   readMux = 32'(state_reg == MFR_IDLE) << `MFR_STAT_IDLE_BIT; // [RL7]
         `MFR_OFS_INT_STAT: readMux = intStat_reg;
         `MFR_OFS_INT_MASK: readMux = intMask_reg;
         default:           readMux = 32'h0000_0000;
      endcase
      wait_next  = !((avsRead || avsWrite) && wait_reg);
      rdata_next = (avsRead && wait_reg) ? readMux : rdata_reg;
      cfg_next   = cfg_reg;
      intMask_next = intMask_reg;
      if (wrTaken && avsAddress == `MFR_OFS_CONFIG) begin
         cfg_next = (cfg_reg & ~beMask) | (avsWritedata & beMask);
      end
      if (wrTaken && avsAddress == `MFR_OFS_INT_MASK) begin
         intMask_next = (intMask_reg & ~beMask) | (avsWritedata & beMask);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cfg_reg     <= `MFR_CFG_RESET;
         intMask_reg <= `MFR_INT_RESET;
         rdata_reg   <= 32'h0000_0000;
         wait_reg    <= 1'b1;
      end else begin
         cfg_reg     <= cfg_next;
         intMask_reg <= intMask_next;
         rdata_reg   <= rdata_next;
         wait_reg    <= wait_next;
      end
   end

   // ==========================================================================
   // frame shifter
   always_comb begin
      state_next  = state_reg;
      frame_next  = frame_reg;
      bitCnt_next = bitCnt_reg;
      sample_next = sample_reg;
      out_next    = out_reg;
      oe_next     = oe_reg;
      doneEvt     = 1'b0;
      readOp_next = readOp_reg;
      case (state_reg)
         MFR_IDLE: begin
            if (wrTaken && avsAddress == `MFR_OFS_FRAME) begin // [RL7]
               frame_next  = (frame_reg & ~beMask) | (avsWritedata & beMask);
               // kind is latched: the kind bits rotate away during the shift
               readOp_next = frame_next[`MFR_KIND_HI:`MFR_KIND_LO] == `MFR_KIND_READ; // [RL3]
               state_next  = MFR_PREAMBLE;
               bitCnt_next = '0;
               out_next    = 1'b1;
               oe_next     = 1'b1;
            end
         end
         MFR_PREAMBLE: begin
            if (fallTick) begin
               bitCnt_next = bitCnt_reg + 6'h01;
               if (bitCnt_reg == `MFR_PREAMBLE_BITS - 6'h01) begin
                  state_next  = MFR_SHIFT;
                  bitCnt_next = '0;
                  out_next    = frame_reg[31]; // [RL8]
               end
            end
         end
         MFR_SHIFT: begin
            if (riseTick) begin
               sample_next = oe_reg ? frame_reg[31] : mdioIn; // [RL8] [RL9]
            end
            if (fallTick) begin
               // clause, kind, port and index bits all leave in place order
               frame_next  = {frame_reg[30:0], sample_reg}; // [RL2] [RL4] [RL5] [RL8]
               bitCnt_next = bitCnt_reg + 6'h01;
               out_next    = frame_reg[30];
               oe_next     = !readOp_reg || (bitCnt_reg + 6'h01 < `MFR_READ_DRIVE);
               if (bitCnt_reg == `MFR_FRAME_BITS - 6'h01) begin
                  state_next  = MFR_IDLE;
                  bitCnt_next = '0;
                  out_next    = 1'b0;
                  oe_next     = 1'b0;
                  doneEvt     = 1'b1; // [RL7]
               end
            end
         end
         default: begin
            state_next = MFR_IDLE;
            oe_next    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg   <= MFR_IDLE;
         frame_reg   <= `MFR_FRAME_RESET;
         readOp_reg  <= 1'b0;
         bitCnt_reg  <= '0;
         sample_reg  <= 1'b0;
         out_reg     <= 1'b0;
         oe_reg      <= 1'b0;
         mdc_reg     <= 1'b0;
      end else begin
         state_reg   <= state_next;
         frame_reg   <= frame_next;
         readOp_reg  <= readOp_next;
         bitCnt_reg  <= bitCnt_next;
         sample_reg  <= sample_next;
         out_reg     <= out_next;
         oe_reg      <= oe_next;
         mdc_reg     <= mdcLevel; // [RL10]
      end
   end

   // ==========================================================================
   // interrupt status and line
   always_comb begin
      // set wins over a same-cycle write-one clear
      intStat_next = intStat_reg;
      if (wrTaken && avsAddress == `MFR_OFS_INT_STAT) begin
         intStat_next = intStat_reg & ~(avsWritedata & beMask);
      end
      if (doneEvt) begin
         intStat_next[`MFR_INT_DONE_BIT] = 1'b1; // [RL7]
      end
      // line follows status and mask at the same edge
      irq_next = |(intStat_next & intMask_next);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         intStat_reg <= `MFR_INT_RESET;
         irq_reg     <= 1'b0;
      end else begin
         intStat_reg <= intStat_next;
         irq_reg     <= irq_next;
      end
   end

   assign avsReaddata    = rdata_reg;
   assign avsWaitrequest = wait_reg;
   assign mdc            = mdc_reg;
   assign mdioOut        = out_reg;
   assign mdioOe         = oe_reg;
   assign irq            = irq_reg;

endmodule // mfr_mdio_frame_register

// ---- tb/mfr_frame_sva.sv ----
// Purpose: bus and pin checks for the frame register
// Assumes: bound to the top module, one clock domain
// Notes:   half period floor of 4 covers the smallest divisor
`timescale 1ns/1ps
`include "mfr_consts.svh"
module mfr_frame_sva (
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset,
   // register bus
   input wire logic [4:0]  avsAddress,
   input wire logic        avsRead,
   input wire logic        avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0]  avsByteenable,
   input wire logic        avsWaitrequest,
   // pins
   input wire logic        mdc,
   input wire logic        mdioOut,
   input wire logic        mdioOe,
   input wire logic        irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic acc, maskWr;
   assign acc = avsWrite && !avsWaitrequest && avsByteenable[0];
   assign maskWr = acc && avsAddress == `MFR_OFS_INT_MASK;
   // ==========================================================
   // assertions and covers
   a_wait_answer: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
      else $error("request not answered in one cycle");
   a_wait_single: assert property (!avsWaitrequest |=> avsWaitrequest)
      else $error("wait low for more than one cycle");
   a_wait_idle: assert property (!(avsRead || avsWrite) && avsWaitrequest |=> avsWaitrequest)
      else $error("answer without request");
   a_preamble_one: assert property ($rose(mdioOe) |-> mdioOut)
      else $error("frame does not open with a one");
   a_mdc_high: assert property ($rose(mdc) |-> mdc[*4])
      else $error("mdc high phase too short");
   a_mdc_low: assert property ($fell(mdc) |-> !mdc[*4])
      else $error("mdc low phase too short");
   a_out_on_fall: assert property (mdioOe && $past(mdioOe) && !$fell(mdc)
      |-> $stable(mdioOut))
      else $error("data changed off the falling edge");
   a_release_fall: assert property ($fell(mdioOe) |-> $fell(mdc))
      else $error("pin released off the falling edge");
   a_irq_idle: assert property ($rose(irq) && !$past(maskWr) |-> !mdioOe && !mdc)
      else $error("interrupt while frame runs");
   a_irq_clear: assert property (acc && avsAddress == `MFR_OFS_INT_STAT && avsWritedata[0]
      && !mdioOe && !mdc |=> !irq)
      else $error("interrupt survives clear");
   a_mask_off: assert property (acc && avsAddress == `MFR_OFS_INT_MASK && !avsWritedata[0]
      |=> !irq)
      else $error("interrupt passes mask");
   c_frame: cover property ($rose(mdioOe));
   c_turn: cover property ($fell(mdioOe) ##[1:8] mdc);
   c_irq: cover property ($rose(irq));
endmodule // mfr_frame_sva
bind mfr_mdio_frame_register mfr_frame_sva mfr_frame_sva_inst (.mclk(mclk), .reset(reset),
   .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
   .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
   .avsWaitrequest(avsWaitrequest), .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .irq(irq));

// ---- tb/mfr_phy_model.sv ----
// Purpose: management side of an attached PHY
// Assumes: 32 preamble bits then 14 header bits before turnaround
// Notes:   line has a pull-up, so a released turnaround bit reads one
`timescale 1ns/1ps
module mfr_phy_model #(
   parameter logic [15:0] REPLY = 16'h3C96
) (
   input wire logic   mclk,
   input wire logic   reset,
   input wire logic   mdc,
   input wire logic   mdioLine,
   input wire logic   hostOe,
   output logic       phyOe,
   output logic       phyOut,
   output logic [63:0] seen
);
   logic mdcQ, oeQ;
   logic [6:0] cnt;
   logic [4:0] left;
   logic [16:0] sh;
   always_ff @(posedge mclk) begin
      mdcQ <= mdc;
      oeQ <= hostOe;
      if (reset || (hostOe && !oeQ)) begin
         cnt <= 7'h00;
         left <= 5'h00;
         phyOe <= 1'b0;
         phyOut <= 1'b1;
      end else if (mdc && !mdcQ) begin
         seen <= {seen[62:0], mdioLine};
         cnt <= cnt + 7'h01;
      end else if (oeQ && !hostOe && cnt == 7'h2E && seen[11:10] == 2'h2) begin
         // first turnaround bit high like the pull-up, then zero and the reply
         phyOe <= 1'b1;
         phyOut <= 1'b1;
         sh <= {1'b0, REPLY};
         left <= 5'h11;
      end else if (!mdc && mdcQ && phyOe) begin
         if (left == 5'h00) begin
            phyOe <= 1'b0;
            phyOut <= 1'b1;
         end else begin
            {phyOut, sh} <= {sh, 1'b0};
            left <= left - 5'h01;
         end
      end
   end
endmodule // mfr_phy_model

// ---- tb/tb_mdio_frame_register.sv ----
// Purpose: register and frame tests of the frame register
// Assumes: reply pattern of the PHY model
// Notes:   bus tasks wait on waitrequest
`timescale 1ns/1ps
`include "mfr_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_mdio_frame_register;
   localparam logic [15:0] REPLY = 16'h3C96;
   logic mclk, reset, avsRead, avsWrite, mdc, mdioOut, mdioOe, irq, avsWaitrequest, phyOe, phyOut;
   logic [4:0] avsAddress;
   logic [31:0] avsWritedata, avsReaddata, rd, wf;
   logic [3:0] avsByteenable;
   logic [63:0] seen;
   int miscompares, checked, cycles, hiCnt, lastHi;
   logic [4:0] adr [6] = '{`MFR_OFS_FRAME, `MFR_OFS_CONFIG, `MFR_OFS_STATUS,
      `MFR_OFS_INT_STAT, `MFR_OFS_INT_MASK, 5'h14};
   logic [31:0] rst [6] = '{`MFR_FRAME_RESET, `MFR_CFG_RESET, 32'h0000_0004,
      `MFR_INT_RESET, 32'h0000_0000, 32'h0000_0000};
   wire logic mdioLine = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
   mfr_mdio_frame_register mfr_mdio_frame_register_inst (.mclk(mclk), .reset(reset),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .mdc(mdc), .mdioIn(mdioLine), .mdioOut(mdioOut),
      .mdioOe(mdioOe), .irq(irq));
   mfr_phy_model #(.REPLY(REPLY)) mfr_phy_model_inst (.mclk(mclk), .reset(reset), .mdc(mdc),
      .mdioLine(mdioLine), .hostOe(mdioOe), .phyOe(phyOe), .phyOut(phyOut), .seen(seen));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (mdc) hiCnt++;
      else if (hiCnt != 0) begin
         lastHi = hiCnt;
         hiCnt = 0;
      end
      if (cycles == 30000) begin
         miscompares++;
         conclude();
      end
   end
   function automatic logic [31:0] mk(input logic c, input logic [1:0] k, input logic [4:0] p,
                                      input logic [4:0] r, input logic [15:0] d);
      return {1'b0, c, k, p, r, `MFR_TA_CODE, d};
   endfunction
   task automatic busWr(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= 1'b1;
      do @(posedge mclk); while (avsWaitrequest !== 1'b0);
      avsWrite <= 1'b0;
   endtask
   task automatic busRd(input logic [4:0] a, output logic [31:0] d);
      @(posedge mclk);
      avsAddress <= a;
      avsRead <= 1'b1;
      do @(posedge mclk); while (avsWaitrequest !== 1'b0);
      d = avsReaddata;
      avsRead <= 1'b0;
   endtask
   task automatic waitDone;
      rd = 32'h0;
      for (int n = 0; n < 3000 && rd[`MFR_STAT_IDLE_BIT] !== 1'b1; n++)
         busRd(`MFR_OFS_STATUS, rd);
      @(negedge mclk);
   endtask
   task automatic conclude;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsAddress = 5'h00;
      avsWritedata = 32'h0;
      avsByteenable = 4'hF;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      busWr(5'h14, 32'hFFFF_FFFF);
      busWr(`MFR_OFS_STATUS, 32'h0);
      for (int i = 0; i < 6; i++) begin
         busRd(adr[i], rd);
         `CHK(rd, rst[i])
      end
      busWr(`MFR_OFS_INT_MASK, 32'h1);
      wf = mk(1'b1, `MFR_KIND_WRITE, 5'h0A, 5'h03, 16'hA5C3);
      busWr(`MFR_OFS_FRAME, wf);
      busRd(`MFR_OFS_STATUS, rd);
      `CHK(rd[`MFR_STAT_IDLE_BIT], 1'b0)
      waitDone();
      `CHK(irq, 1'b1)
      busRd(`MFR_OFS_FRAME, rd);
      `CHK(rd, wf)
      `CHK(seen, {32'hFFFF_FFFF, wf})
      `CHK(lastHi, `MFR_DIV2 / 2)
      busWr(`MFR_OFS_INT_STAT, 32'h1);
      @(negedge mclk);
      `CHK(irq, 1'b0)
      wf = mk(1'b0, `MFR_KIND_READ, 5'h11, 5'h1F, 16'h0000);
      busWr(`MFR_OFS_FRAME, wf);
      busWr(`MFR_OFS_FRAME, 32'h5000_0000);
      waitDone();
      busRd(`MFR_OFS_FRAME, rd);
      `CHK(rd, {wf[31:16], REPLY})
      `CHK(irq, 1'b1)
      busWr(`MFR_OFS_INT_STAT, 32'h1);
      busWr(`MFR_OFS_INT_MASK, 32'h0);
      busWr(`MFR_OFS_CONFIG, 32'h0);
      busRd(`MFR_OFS_CONFIG, rd);
      `CHK(rd, 32'h0)
      wf = mk(1'b1, `MFR_KIND_WRITE, 5'h1F, 5'h00, 16'hFFFF);
      busWr(`MFR_OFS_FRAME, wf);
      waitDone();
      `CHK(irq, 1'b0)
      `CHK(seen[31:0], wf)
      `CHK(lastHi, `MFR_DIV0 / 2)
      busRd(`MFR_OFS_INT_STAT, rd);
      `CHK(rd, 32'h1)
      busWr(`MFR_OFS_INT_MASK, 32'h1);
      @(negedge mclk);
      `CHK(irq, 1'b1)
      conclude();
   end
endmodule // tb_mdio_frame_register
